/* File: verilog/flash_lock_cfg.svh */
`ifndef FLASH_LOCK_CFG_SVH
`define FLASH_LOCK_CFG_SVH

// field positions inside one lock register
`define WR_LOCK_BIT      0
`define FREEZE_BIT       1
`define RD_LOCK_BIT      2

// power-up value and the answer of an empty slot
`define LOCK_RESET_VAL   8'h01
`define UNUSED_READ_VAL  8'h00
`define LOCK_REG_NUM     8

// window claimed by the lock registers: ffbx_x002
`define LOCK_WIN_TOP     12'hffb
`define LOCK_WIN_LOW     15'h0002

// 4 mbit density, one register per 64 kbyte block
`define LOCK_4M_BLOCK0         32'hffb80002
`define LOCK_4M_BLOCK1         32'hffb90002
`define LOCK_4M_BLOCK2         32'hffba0002
`define LOCK_4M_BLOCK3         32'hffbb0002
`define LOCK_4M_BLOCK4         32'hffbc0002
`define LOCK_4M_BLOCK5         32'hffbd0002
`define LOCK_4M_BLOCK6         32'hffbe0002
`define LOCK_4M_BOOT_BLOCK     32'hffbf0002

// 2 mbit density, registers over groups of 16 kbyte blocks
`define LOCK_2M_BLOCKS_1_0     32'hffbc0002
`define LOCK_2M_BLOCKS_3_2     32'hffbc8002
`define LOCK_2M_BLOCKS_5_4     32'hffbd0002
`define LOCK_2M_BLOCKS_7_6     32'hffbd8002
`define LOCK_2M_BLOCKS_9_8     32'hffbe0002
`define LOCK_2M_BLOCKS_11_10   32'hffbe8002
`define LOCK_2M_BLOCKS_14_12   32'hffbf0002
`define LOCK_2M_BOOT_BLOCK     32'hffbf8002

// array address fields selecting a block
`define BLK16K_MSB       17
`define BLK16K_LSB       14
`define BLK64K_MSB       18
`define BLK64K_LSB       16
`define BOOT16K_BLOCK    4'hf
`define TRIPLE16K_FIRST  4'hc

`endif

/* File: verilog/flash_lock_pkg.sv */
package flash_lock_pkg;
`include "flash_lock_cfg.svh"

    // operation asked for by the array core
    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_ERASE   = 2'h2
    } arrayOp_t;

    // one lock register, bits 2..0
    typedef struct packed {
        logic rdLock;
        logic freeze;
        logic wrLock;
    } lockBits_t;

    typedef lockBits_t [`LOCK_REG_NUM-1:0] lockBank_t;

    // decoded host memory cycle
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } memCmd_t;

    typedef struct packed {
        logic       valid;
        logic       claimed;
        logic [7:0] rdata;
    } memRsp_t;

    typedef struct packed {
        logic        valid;
        arrayOp_t    op;
        logic [18:0] arrayAddr;
    } chkReq_t;

    typedef struct packed {
        logic valid;
        logic allow;
    } chkRsp_t;

    typedef struct packed {
        logic       hit;
        logic       mapped;
        logic [2:0] idx;
    } regSel_t;

    // register address to slot; hit covers empty slots of the window too
    function automatic regSel_t decodeRegAddr(input logic [31:0] a, input logic is4m);
        regSel_t s;
        s        = '0;
        s.hit    = (a[31:20] == `LOCK_WIN_TOP) && (a[14:0] == `LOCK_WIN_LOW);
        s.mapped = 1'b1;
        if (is4m) begin
            case (a)
                `LOCK_4M_BLOCK0:     s.idx = 3'h0;
                `LOCK_4M_BLOCK1:     s.idx = 3'h1;
                `LOCK_4M_BLOCK2:     s.idx = 3'h2;
                `LOCK_4M_BLOCK3:     s.idx = 3'h3;
                `LOCK_4M_BLOCK4:     s.idx = 3'h4;
                `LOCK_4M_BLOCK5:     s.idx = 3'h5;
                `LOCK_4M_BLOCK6:     s.idx = 3'h6;
                `LOCK_4M_BOOT_BLOCK: s.idx = 3'h7;
                default:             s.mapped = 1'b0;
            endcase
        end else begin
            case (a)
                `LOCK_2M_BLOCKS_1_0:   s.idx = 3'h0;
                `LOCK_2M_BLOCKS_3_2:   s.idx = 3'h1;
                `LOCK_2M_BLOCKS_5_4:   s.idx = 3'h2;
                `LOCK_2M_BLOCKS_7_6:   s.idx = 3'h3;
                `LOCK_2M_BLOCKS_9_8:   s.idx = 3'h4;
                `LOCK_2M_BLOCKS_11_10: s.idx = 3'h5;
                `LOCK_2M_BLOCKS_14_12: s.idx = 3'h6;
                `LOCK_2M_BOOT_BLOCK:   s.idx = 3'h7;
                default:               s.mapped = 1'b0;
            endcase
        end
        return s;
    endfunction

    // array address to the slot guarding it
    function automatic logic [2:0] blockToIndex(input logic [18:0] a, input logic is4m);
        logic [3:0] b;
        b = a[`BLK16K_MSB:`BLK16K_LSB];
        if (is4m) begin
            return a[`BLK64K_MSB:`BLK64K_LSB];
        end else if (b == `BOOT16K_BLOCK) begin
            return 3'h7;
        end else if (b >= `TRIPLE16K_FIRST) begin
            return 3'h6;
        end
        return b[3:1];
    endfunction

endpackage

/* File: verilog/lock_addr_decode.sv */
`timescale 1ns/1ns
module lock_addr_decode #(
    parameter bit IS_4MBIT = 1'b1                // density strap
) (
    input  wire logic [31:0]            regAddr,   // host memory address
    input  wire logic [18:0]            arrayAddr, // array address to check
    output flash_lock_pkg::regSel_t     regSel,    // register slot decode
    output logic [2:0]                  chkIdx     // slot guarding arrayAddr
);
    import flash_lock_pkg::*;

    // both decodes are pure functions of the address
    always_comb begin
        regSel = decodeRegAddr(regAddr, IS_4MBIT);
        chkIdx = blockToIndex(arrayAddr, IS_4MBIT);
    end
endmodule

/* File: verilog/lock_reg_bank.sv */
`timescale 1ns/1ns
`include "flash_lock_cfg.svh"
module lock_reg_bank (
    input  wire logic                 mclk,    // clock
    input  wire logic                 rst,     // power-on reset
    input  wire logic                 hwReset, // reset or init pin held
    input  wire logic                 wrEn,    // accepted write
    input  wire logic [2:0]           wrIdx,   // slot written
    input  wire logic [7:0]           wrData,  // written byte
    output flash_lock_pkg::lockBank_t lockQ    // stored lock bits
);
    import flash_lock_pkg::*;

    localparam logic [7:0] RST_BYTE = `LOCK_RESET_VAL;

    lockBank_t nxt_lockQ;

    genvar gi;
    generate
        for (gi = 0; gi < `LOCK_REG_NUM; gi++) begin : g_slot
            // reserved bits are never stored, so they always read back zero
            always_comb begin
                nxt_lockQ[gi] = lockQ[gi];
                if (hwReset) begin
                    nxt_lockQ[gi] = lockBits_t'(RST_BYTE[2:0]);
                end else if (wrEn && (wrIdx == 3'(gi))) begin
                    if (!lockQ[gi].freeze) begin
                        nxt_lockQ[gi].wrLock = wrData[`WR_LOCK_BIT];
                        nxt_lockQ[gi].rdLock = wrData[`RD_LOCK_BIT];
                    end
                    nxt_lockQ[gi].freeze = lockQ[gi].freeze | wrData[`FREEZE_BIT];
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    lockQ[gi] <= lockBits_t'(RST_BYTE[2:0]);
                end else begin
                    lockQ[gi] <= nxt_lockQ[gi];
                end
            end
        end
    endgenerate
endmodule

/* File: verilog/flash_block_lock_regs.sv */
`timescale 1ns/1ns
`include "flash_lock_cfg.svh"
// Summary of operation
// - write-lock bit set refuses program and erase in the guarded block.
// - read-lock bit set blocks reads of the guarded block.
// - with freeze set, writes cannot change write-lock or read-lock bits.
// - freeze can be set by a write, never cleared by one.
// - reset pin, init pin or power-on reset clear the freeze.
// - every lock register powers up holding 01h.
// - value 02h leaves block open and freezes that open state.
// - value 07h locks reads and writes, frozen; bits 7..3 zero.
// - 2 mbit map, eight registers ffbc0002h to ffbf8002h, step 8000h.
// - 4 mbit map, eight registers ffb80002h to ffbf0002h, step 10000h.
// - each register is eight bits, host readable and writable.
// - an unused lock register location reads 00h.
module flash_block_lock_regs #(
    parameter bit IS_4MBIT = 1'b1                    // density strap, 1 = 4 mbit
) (
    input  wire logic                  mclk,         // host bus clock
    input  wire logic                  rst,          // power-on reset
    input  wire logic                  resetPinN,    // hardware reset pin
    input  wire logic                  initPinN,     // processor init pin
    input  flash_lock_pkg::memCmd_t    memCmd,       // host memory cycle
    output logic                       cmdReady,     // cycle may be taken
    output flash_lock_pkg::memRsp_t    memRsp,       // answer to host cycle
    input  flash_lock_pkg::chkReq_t    chkReq,       // array access query
    output flash_lock_pkg::chkRsp_t    chkRsp,       // access verdict
    output flash_lock_pkg::lockBank_t  lockState     // all lock bits
);
    import flash_lock_pkg::*;

    localparam logic [7:0]  RST_BYTE    = `LOCK_RESET_VAL;
    localparam logic [7:0]  EMPTY_BYTE  = `UNUSED_READ_VAL;
    localparam lockBank_t   DEFAULT_ALL = {`LOCK_REG_NUM{RST_BYTE[2:0]}};
    localparam logic [31:0] MAP_BASE    = IS_4MBIT ? `LOCK_4M_BLOCK0 : `LOCK_2M_BLOCKS_1_0;
    localparam logic [31:0] MAP_STEP    = IS_4MBIT ? (`LOCK_4M_BLOCK1 - `LOCK_4M_BLOCK0)
                                                   : (`LOCK_2M_BLOCKS_3_2 - `LOCK_2M_BLOCKS_1_0);

    // bus side sequencing
    typedef enum logic [2:0] {
        ST_RESET  = 3'b001,
        ST_IDLE   = 3'b010,
        ST_ANSWER = 3'b100
    } busState_t;

    busState_t  state_ff;
    busState_t  nxt_state;
    logic       cmdReady_ff;
    logic       nxt_cmdReady;
    memRsp_t    memRsp_ff;
    memRsp_t    nxt_memRsp;
    chkRsp_t    chkRsp_ff;
    chkRsp_t    nxt_chkRsp;
    regSel_t    sel;
    logic [2:0] chkIdx;
    logic       hwReset;
    logic       take;
    logic       wrEn;
    lockBank_t  lockQ;

    // either pin low acts as a hardware reset of the lock bank
    assign hwReset = !resetPinN || !initPinN;

    lock_addr_decode #(
        .IS_4MBIT (IS_4MBIT)
    ) u_decode (
        .regAddr   (memCmd.addr),
        .arrayAddr (chkReq.arrayAddr),
        .regSel    (sel),
        .chkIdx    (chkIdx)
    );

    // a cycle is taken only while idle and outside hardware reset
    assign take = (state_ff == ST_IDLE) && cmdReady_ff && memCmd.valid && !hwReset;
    // host writes reach mapped slots only
    assign wrEn = take && memCmd.write && sel.mapped;

    // freeze handling lives in the bank
    lock_reg_bank u_bank (
        .mclk    (mclk),
        .rst     (rst),
        .hwReset (hwReset),
        .wrEn    (wrEn),
        .wrIdx   (sel.idx),
        .wrData  (memCmd.wdata),
        .lockQ   (lockQ)
    );

    // state walk: one answer cycle per taken command
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET: begin
                if (!hwReset) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (hwReset) begin
                    nxt_state = ST_RESET;
                end else if (take) begin
                    nxt_state = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                nxt_state = hwReset ? ST_RESET : ST_IDLE;
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
        nxt_cmdReady = (nxt_state == ST_IDLE);
    end

    // answer to the host; writes read back zero, frozen writes still complete
    // frozen write answers
    always_comb begin
        nxt_memRsp         = '0;
        nxt_memRsp.valid   = take;
        nxt_memRsp.claimed = take && sel.hit;
        if (take && !memCmd.write && sel.hit) begin
            if (sel.mapped) begin
                nxt_memRsp.rdata = {5'h00, lockQ[sel.idx]};
            end else begin
                nxt_memRsp.rdata = EMPTY_BYTE;
            end
        end
    end

    // access verdict for the array core; unknown operations are refused
    always_comb begin
        nxt_chkRsp       = '0;
        nxt_chkRsp.valid = chkReq.valid;
        case (chkReq.op)
            OP_READ:    nxt_chkRsp.allow = chkReq.valid && !lockQ[chkIdx].rdLock;
            OP_PROGRAM: nxt_chkRsp.allow = chkReq.valid && !lockQ[chkIdx].wrLock;
            OP_ERASE:   nxt_chkRsp.allow = chkReq.valid && !lockQ[chkIdx].wrLock;
            default:    nxt_chkRsp.allow = 1'b0;
        endcase
    end

    // registers of the bus side and the verdict
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_RESET;
            cmdReady_ff <= 1'b0;
            memRsp_ff   <= '0;
            chkRsp_ff   <= '0;
        end else begin
            state_ff    <= nxt_state;
            cmdReady_ff <= nxt_cmdReady;
            memRsp_ff   <= nxt_memRsp;
            chkRsp_ff   <= nxt_chkRsp;
        end
    end

    assign cmdReady  = cmdReady_ff;
    assign memRsp    = memRsp_ff;
    assign chkRsp    = chkRsp_ff;
    assign lockState = lockQ;

    // helper: freeze bits as a vector and a first-cycle marker
    logic [`LOCK_REG_NUM-1:0] freezeVec;
    logic                     firstCycle_ff;

    always_comb begin
        for (int i = 0; i < `LOCK_REG_NUM; i++) begin
            freezeVec[i] = lockQ[i].freeze;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            firstCycle_ff <= 1'b1;
        end else begin
            firstCycle_ff <= 1'b0;
        end
    end

    AST_WR_LOCK_DENIES: assert property (@(posedge mclk) disable iff (rst)
        (chkReq.valid && chkReq.op != OP_READ && lockQ[chkIdx].wrLock)
        |=> (chkRsp.valid && !chkRsp.allow))
        else $error("program or erase allowed in a write-locked block");

    AST_WR_OPEN_ALLOWS: assert property (@(posedge mclk) disable iff (rst)
        (chkReq.valid && (chkReq.op == OP_PROGRAM || chkReq.op == OP_ERASE)
         && !lockQ[chkIdx].wrLock)
        |=> chkRsp.allow)
        else $error("program or erase refused in an unlocked block");

    AST_RD_LOCK: assert property (@(posedge mclk) disable iff (rst)
        (chkReq.valid && chkReq.op == OP_READ)
        |=> (chkRsp.valid && chkRsp.allow == !$past(lockQ[chkIdx].rdLock)))
        else $error("read verdict does not follow the read-lock bit");

    AST_FROZEN_HOLDS: assert property (@(posedge mclk) disable iff (rst)
        (wrEn && lockQ[sel.idx].freeze)
        |=> (lockQ[$past(sel.idx)] == $past(lockQ[sel.idx])))
        else $error("lock bits changed in a frozen register");

    AST_FREEZE_STICKY: assert property (@(posedge mclk) disable iff (rst)
        (|($past(freezeVec) & ~freezeVec)) |-> $past(hwReset))
        else $error("freeze bit cleared without a hardware reset");

    AST_HW_RESET_CLEARS: assert property (@(posedge mclk) disable iff (rst)
        hwReset |=> (lockQ == DEFAULT_ALL && freezeVec == '0))
        else $error("reset or init pin did not restore the lock bank");

    AST_POWER_UP_VALUE: assert property (@(posedge mclk) disable iff (rst)
        firstCycle_ff |-> (lockQ == DEFAULT_ALL))
        else $error("lock registers not 01h after power-on reset");

    AST_LOCKED_OPEN: assert property (@(posedge mclk) disable iff (rst)
        (wrEn && memCmd.wdata == 8'h02 && !lockQ[sel.idx].freeze)
        |=> (lockQ[$past(sel.idx)] == lockBits_t'(3'h2)))
        else $error("02h did not lock the block open");

    AST_FULL_LOCKDOWN: assert property (@(posedge mclk) disable iff (rst)
        (wrEn && memCmd.wdata == 8'h07 && !lockQ[sel.idx].freeze)
        |=> (lockQ[$past(sel.idx)] == lockBits_t'(3'h7)) ##1
            (lockQ[$past(sel.idx, 2)].freeze || $past(hwReset)))
        else $error("07h did not lock and freeze the block");

    AST_MAP_ADDRESS: assert property (@(posedge mclk) disable iff (rst)
        sel.mapped |-> (memCmd.addr == MAP_BASE + 32'(MAP_STEP * {29'h0, sel.idx})))
        else $error("slot decoded at a wrong address");

    AST_READ_BACK: assert property (@(posedge mclk) disable iff (rst)
        (take && !memCmd.write && sel.mapped)
        |=> (memRsp.valid && memRsp.claimed
             && memRsp.rdata == {5'h00, $past(lockQ[sel.idx])}))
        else $error("register read returned wrong data");

    AST_UNUSED_ZERO: assert property (@(posedge mclk) disable iff (rst)
        (take && !memCmd.write && sel.hit && !sel.mapped)
        |=> (memRsp.valid && memRsp.claimed && memRsp.rdata == 8'h00))
        else $error("unused location did not read 00h");

    AST_FROZEN_WRITE_DONE: assert property (@(posedge mclk) disable iff (rst)
        (wrEn && lockQ[sel.idx].freeze && !hwReset)
        |=> (memRsp.valid && memRsp.claimed && !cmdReady) ##1 (cmdReady || $past(hwReset)))
        else $error("write to frozen register did not complete");

endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ns
// host side of the memory cycle port, one cycle in flight at a time
module host_model (
    input  wire logic               mclk,     // host bus clock
    input  wire logic               cmdReady, // device takes the cycle
    output flash_lock_pkg::memCmd_t memCmd    // memory cycle to device
);
    import flash_lock_pkg::*;

    initial memCmd = '0;

    // request held until ready is sampled high, then released
    task automatic access(input logic wr, input logic [31:0] a, input logic [7:0] d);
        memCmd <= '{1'b1, wr, a, d};
        // ready moves only on the rising edge, so its value at the falling
        // edge is what the device sees at the next rising edge
        forever begin
            @(negedge mclk);
            if (cmdReady === 1'b1) break;
        end
        @(posedge mclk);
        // idle bus must not keep the last value, so scramble it
        memCmd <= '{1'b0, ~wr, ~a, ~d};
        @(posedge mclk);
    endtask
endmodule

/* File: tb/flash_block_lock_regs_tb.sv */
`timescale 1ns/1ns
module flash_block_lock_regs_tb;
    import flash_lock_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        resetPinN = 1'b1;
    logic        initPinN = 1'b1;
    memCmd_t     memCmd;
    chkReq_t     chkReq = '0;
    logic        rdy4, rdy2;
    memRsp_t     rsp4, rsp2;
    chkRsp_t     chk4, chk2;
    lockBank_t   lock4, lock2;
    logic [2:0]  lockRef [2][8];
    logic [17:0] memQ [$];
    logic [1:0]  chkQ [$];
    logic [17:0] memE;
    logic [1:0]  chkE;
    logic [31:0] a;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #5 mclk = ~mclk;

    // both densities see the same traffic, so one run covers both maps
    flash_block_lock_regs #(.IS_4MBIT(1'b1)) u_dut (.mclk(mclk), .rst(rst),
        .resetPinN(resetPinN), .initPinN(initPinN), .memCmd(memCmd), .cmdReady(rdy4),
        .memRsp(rsp4), .chkReq(chkReq), .chkRsp(chk4), .lockState(lock4));
    flash_block_lock_regs #(.IS_4MBIT(1'b0)) u_dut2m (.mclk(mclk), .rst(rst),
        .resetPinN(resetPinN), .initPinN(initPinN), .memCmd(memCmd), .cmdReady(rdy2),
        .memRsp(rsp2), .chkReq(chkReq), .chkRsp(chk2), .lockState(lock2));
    host_model u_host (.mclk(mclk), .cmdReady(rdy4), .memCmd(memCmd));

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // register address of slot i, d = 1 for the 4 mbit map
    function automatic logic [31:0] regAddr(input int d, input int i);
        return d ? 32'hffb80002 + i * 32'h10000 : 32'hffbc0002 + i * 32'h8000;
    endfunction

    // -2 outside the window, -1 empty slot inside it
    function automatic int slotOf(input logic [31:0] x, input int d);
        if (x[31:20] != 12'hffb || x[14:0] != 15'h0002) return -2;
        for (int i = 0; i < 8; i++) begin
            if (x == regAddr(d, i)) return i;
        end
        return -1;
    endfunction

    function automatic logic [8:0] expMem(input logic wr, input logic [31:0] x, input int d);
        int s;
        s = slotOf(x, d);
        if (s == -2) return 9'h000;
        if (wr || s < 0) return 9'h100;
        return {4'h8, 2'b0, lockRef[d][s]};
    endfunction

    function automatic logic expAllow(input int d, input logic [1:0] op, input logic [18:0] x);
        logic [2:0] b;
        b = d ? x[18:16] : (x[17:14] == 4'hf ? 3'h7 : (x[17:14] >= 4'hc ? 3'h6 : x[17:15]));
        case (op)
            2'h0: return ~lockRef[d][b][2];
            2'h1, 2'h2: return ~lockRef[d][b][0];
            default: return 1'b0;
        endcase
    endfunction

    // note the answer, update the reference, then run the cycle
    task automatic mem(input logic wr, input logic [31:0] x, input logic [7:0] d);
        int s;
        memQ.push_back({expMem(wr, x, 1), expMem(wr, x, 0)});
        for (int k = 0; k < 2; k++) begin
            s = slotOf(x, k);
            if (wr && s >= 0 && !lockRef[k][s][1]) lockRef[k][s] = d[2:0];
        end
        u_host.access(wr, x, d);
    endtask

    task automatic chk(input logic [1:0] op, input logic [18:0] x);
        chkQ.push_back({expAllow(1, op, x), expAllow(0, op, x)});
        chkReq <= '{1'b1, arrayOp_t'(op), x};
        @(posedge mclk);
    endtask

    task automatic readAll();
        for (int i = 0; i < 8; i++) begin
            mem(1'b0, regAddr(1, i), 8'h00);
            mem(1'b0, regAddr(0, i), 8'h00);
        end
    endtask

    // pin reset reloads every slot with the power-up value
    task automatic pinReset(input bit useInit);
        if (useInit) initPinN <= 1'b0;
        else resetPinN <= 1'b0;
        repeat (2) @(posedge mclk);
        initPinN <= 1'b1;
        resetPinN <= 1'b1;
        @(posedge mclk);
        lockRef = '{default: 3'h1};
    endtask

    // answers pair with the oldest outstanding note; looked at mid-cycle,
    // where the registered answers have settled
    always @(negedge mclk) begin
        if (rsp4.valid === 1'b1 || rsp2.valid === 1'b1) begin
            memE = memQ.size() ? memQ.pop_front() : 18'h3ffff;
            check("memRsp 4m", 24'({rsp4.valid, rsp4.claimed, rsp4.rdata}), 24'({1'b1, memE[17:9]}));
            check("memRsp 2m", 24'({rsp2.valid, rsp2.claimed, rsp2.rdata}), 24'({1'b1, memE[8:0]}));
            check("cmdReady", 24'({rdy4, rdy2}), 24'h0);
        end
        if (chk4.valid === 1'b1 || chk2.valid === 1'b1) begin
            chkE = chkQ.size() ? chkQ.pop_front() : 2'bxx;
            check("chkRsp", 24'({chk4.valid, chk4.allow, chk2.valid, chk2.allow}), 24'({1'b1, chkE[1], 1'b1, chkE[0]}));
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        lockRef = '{default: 3'h1};
        void'($urandom(32'h9be0a843));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("lockState 4m", 24'(lock4), {8{3'h1}});
        check("lockState 2m", 24'(lock2), {8{3'h1}});
        readAll();
        // empty slot in the window, a place outside it, a write outside it
        mem(1'b0, 32'hffb88002, 8'h00);
        mem(1'b0, 32'hffbc0100, 8'h00);
        mem(1'b1, 32'hffbc0100, 8'h07);
        $display("test power-up and maps done");

        // every documented code, reserved bits random, then a second write
        for (int c = 0; c < 8; c++) begin
            a = regAddr(c % 2, $urandom_range(7));
            mem(1'b1, a, {5'($urandom), 3'(c)});
            mem(1'b0, a, 8'h00);
            mem(1'b1, a, 8'($urandom));
            mem(1'b0, a, 8'h00);
            // back-to-back checks on every op code
            for (int k = 0; k < 8; k++) begin
                chk(2'(k), {a[18:16] ^ 3'(c % 2 ? 0 : 4), 16'($urandom)});
            end
            chkReq.valid <= 1'b0;
            pinReset(c % 2 == 1);
            mem(1'b0, a, 8'h00);
        end
        $display("test lock codes done");

        for (int i = 0; i < 8; i++) begin
            mem(1'b1, regAddr(1, i), 8'h07);
            mem(1'b1, regAddr(0, i), 8'h07);
        end
        // clearing a frozen slot is accepted and ignored
        mem(1'b1, regAddr(1, 3), 8'h00);
        readAll();
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        lockRef = '{default: 3'h1};
        readAll();
        $display("test freeze and power-on reset done");

        repeat (4) @(posedge mclk);
        check("pending notes", 24'(memQ.size() + chkQ.size()), 24'h0);
        close_out();
    end
endmodule
